// ### testbench/cpd_decoder_monitor.sv
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
module cpd_decoder_monitor #(
   parameter int CNT_W = 4,
   parameter int STATE_W = 8
) (
   // Clock, reset and request
   input wire logic core_clk, sys_rst, decValid, periphAccess, periphSlow,
   input wire logic [15:0] instrWord, instrWord2, stackPtr, progCounter,
   // Decode result
   input wire logic outValid, altSelect, dataMove, illegalOp, periphFault, busy,
   input wire logic [7:0] opCode,
   input cpd_pkg::cpd_class_t opClass,
   input wire logic [CNT_W-1:0] cntFetch, cntBranch, cntStack, cntByte, cntWord, cntInternal,
   input wire logic [STATE_W-1:0] execStates,
   // Indirect call sequence
   input wire logic spWrite, pushWrite, vecRead,
   input wire logic [15:0] spNext, pushData,
   input wire logic [7:0] vecAddr
);
   logic slowQ;
   logic [STATE_W-1:0] sumStates;
   logic [CNT_W-1:0] cntJk, cntRest;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Byte cost class of the request now shown
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         slowQ <= 1'b0;
      else if (decValid && !busy)
         slowQ <= periphAccess && periphSlow;
   end
   // Weighted sum and grouped counts
   assign sumStates = STATE_W'(2 * (cntFetch + cntBranch + cntStack + cntWord) + cntInternal
      + cntByte * (slowQ ? 3 : 2));
   assign cntJk = cntBranch | cntStack;
   assign cntRest = cntWord | cntInternal;
   a_opcode_field: assert property (decValid && !busy |=> opCode == $past(instrWord[15:8]))
      else $error("opcode byte not from upper byte");
   a_alt_clear: assert property (decValid && !busy && !instrWord[7] |=> !altSelect)
      else $error("alternate select without bit 7");
   a_state_sum: assert property (outValid |-> execStates == sumStates)
      else $error("state total wrong");
   a_alu_counts: assert property (outValid && opClass == cpd_pkg::CL_ALU
      |-> cntFetch == 1 && cntByte == 0 && cntJk == 0 && cntRest == 0)
      else $error("alu counts wrong");
   a_rmw_counts: assert property (outValid && opClass == cpd_pkg::CL_BIT_RMW
      |-> cntFetch == 2 && cntByte == 2 && cntJk == 0 && cntRest == 0)
      else $error("bit rmw counts wrong");
   a_call_counts: assert property (outValid && opClass == cpd_pkg::CL_CALL_IND
      |-> cntFetch == 2 && cntBranch == 1 && cntStack == 1 && cntByte == 0 && cntRest == 0)
      else $error("call counts wrong");
   a_bit_reg: assert property (outValid && opClass == cpd_pkg::CL_BIT_REG
      |-> cntFetch == 1 && cntByte == 0 && cntJk == 0 && cntRest == 0)
      else $error("bit register counts wrong");
   a_bit_read: assert property (outValid && opClass == cpd_pkg::CL_BIT_RD
      |-> cntFetch == 2 && cntByte == 1 && cntJk == 0 && cntRest == 0)
      else $error("bit read counts wrong");
   a_call_order: assert property (outValid && opClass == cpd_pkg::CL_CALL_IND
      |-> busy && !spWrite ##1 spWrite && !pushWrite ##1 pushWrite ##1 vecRead && !busy)
      else $error("call sequence out of order");
   a_sp_step: assert property (spWrite |-> spNext == $past(stackPtr) - 16'h0002)
      else $error("stack pointer step wrong");
   a_call_vector: assert property (outValid && opClass == cpd_pkg::CL_CALL_IND
      |-> vecAddr == $past(instrWord[7:0]) && pushData == $past(progCounter))
      else $error("vector or pushed word wrong");
   a_busy_refuse: assert property (busy |=> !outValid)
      else $error("request taken while busy");
   a_illegal_flag: assert property (outValid
      |-> illegalOp == (opClass == cpd_pkg::CL_ILLEGAL))
      else $error("illegal flag disagrees with class");
   a_periph_fault: assert property (decValid && !busy
      |=> periphFault == ($past(periphAccess) && cntByte == 0))
      else $error("peripheral fault flag wrong");
   c_call_done: cover property (vecRead);
   c_slow_periph: cover property (outValid && slowQ);
   c_illegal_seen: cover property (outValid && illegalOp);
endmodule

bind cpd_decoder cpd_decoder_monitor #(.CNT_W(CNT_W), .STATE_W(STATE_W)) cpd_decoder_monitor_inst (
   .core_clk(core_clk), .sys_rst(sys_rst), .decValid(decValid), .periphAccess(periphAccess),
   .periphSlow(periphSlow), .instrWord(instrWord), .instrWord2(instrWord2),
   .stackPtr(stackPtr), .progCounter(progCounter), .outValid(outValid),
   .altSelect(altSelect), .dataMove(dataMove), .illegalOp(illegalOp),
   .periphFault(periphFault), .busy(busy), .opCode(opCode), .opClass(opClass),
   .cntFetch(cntFetch), .cntBranch(cntBranch), .cntStack(cntStack), .cntByte(cntByte),
   .cntWord(cntWord), .cntInternal(cntInternal), .execStates(execStates),
   .spWrite(spWrite), .pushWrite(pushWrite), .vecRead(vecRead), .spNext(spNext),
   .pushData(pushData), .vecAddr(vecAddr));

// ### testbench/cpd_mem_model.sv
// On-chip RAM side: stack pointer and stacked word
`timescale 1ns/10ps
module cpd_mem_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Writes from the call sequence
   input wire logic spWrite,
   input wire logic [15:0] spNext,
   input wire logic pushWrite,
   input wire logic [15:0] pushData,
   // Current stack pointer and top of stack
   output logic [15:0] stackPtr,
   output logic [15:0] stackTop
);
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stackPtr <= 16'hff80;
         stackTop <= 16'h0000;
      end
      else
      begin
         if (spWrite)
            stackPtr <= spNext;
         if (pushWrite)
            stackTop <= pushData;
      end
   end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the opcode decoder and state accounting block
`timescale 1ns/10ps
module testbench;
   logic core_clk, sys_rst, decValid, periphAccess, periphSlow;
   logic [15:0] instrWord, instrWord2, progCounter, stackPtr, stackTop, spNext, pushData, sp0;
   logic outValid, altSelect, dataMove, illegalOp, periphFault, busy, spWrite, pushWrite, vecRead;
   logic [7:0] opCode, vecAddr, execStates;
   cpd_pkg::cpd_class_t opClass;
   logic [3:0] cntFetch, cntBranch, cntStack, cntByte, cntWord, cntInternal;
   logic [31:0] rnd;
   integer seed;
   int miscompares, checksDone, cycles;
   logic [7:0] badOps [$] = '{8'h52, 8'h53, 8'h57, 8'h58, 8'h5c, 8'h64, 8'h65, 8'h66, 8'h78,
      8'h79, 8'h7a};

   cpd_decoder #(.CNT_W(4), .STATE_W(8)) cpd_decoder_inst (.core_clk(core_clk),
      .sys_rst(sys_rst), .decValid(decValid), .instrWord(instrWord), .instrWord2(instrWord2),
      .periphAccess(periphAccess), .periphSlow(periphSlow), .stackPtr(stackPtr),
      .progCounter(progCounter), .outValid(outValid), .opCode(opCode), .opClass(opClass),
      .altSelect(altSelect), .dataMove(dataMove), .illegalOp(illegalOp),
      .periphFault(periphFault), .cntFetch(cntFetch), .cntBranch(cntBranch),
      .cntStack(cntStack), .cntByte(cntByte), .cntWord(cntWord), .cntInternal(cntInternal),
      .execStates(execStates), .busy(busy), .spWrite(spWrite), .spNext(spNext),
      .pushWrite(pushWrite), .pushData(pushData), .vecRead(vecRead), .vecAddr(vecAddr));
   cpd_mem_model cpd_mem_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .spWrite(spWrite), .spNext(spNext), .pushWrite(pushWrite), .pushData(pushData),
      .stackPtr(stackPtr), .stackTop(stackTop));

   // Clock source
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
   begin
      checksDone++;
      if (got !== expv)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
      end
   end
   endtask

   // Expected state total from cycle counts
   function automatic int model(input int i, j, k, l, cost);
      return 2 * (i + j + k) + l * cost;
   endfunction

   // One request at a falling edge; result checked one cycle on
   task automatic run(input logic [15:0] w, w2, input logic pa, ps, input int cls, i, j, k, l);
   begin
      rnd = $random(seed);
      decValid = 1'b1;
      instrWord = w;
      instrWord2 = w2;
      periphAccess = pa;
      periphSlow = ps;
      progCounter = rnd[15:0];
      @(negedge core_clk);
      chk("outValid", 16'h1, outValid);
      chk("opCode", w[15:8], opCode);
      chk("opClass", cls, opClass);
      chk("illegalOp", cls == 7, illegalOp);
      chk("periphFault", pa && l == 0, periphFault);
      if (i >= 0)
      begin
         chk("cntFetch", i, cntFetch);
         chk("cntBranch", j, cntBranch);
         chk("cntStack", k, cntStack);
         chk("cntByte", l, cntByte);
         chk("cntWordInt", 16'h0, {cntWord, cntInternal});
         chk("execStates", model(i, j, k, l, (pa && ps) ? 3 : 2), execStates);
      end
   end
   endtask

   task automatic endOfTest;
   begin
      $display("Checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask

   // Cycle ceiling against a hung run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         endOfTest;
      end
   end

   initial
   begin
      seed = 32'h7fc14d9b;
      miscompares = 0;
      checksDone = 0;
      cycles = 0;
      sys_rst = 1'b1;
      decValid = 1'b0;
      instrWord = 16'h0000;
      instrWord2 = 16'h0000;
      periphAccess = 1'b0;
      periphSlow = 1'b0;
      progCounter = 16'h0000;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      // Back-to-back register and immediate forms
      run(16'h8012, 16'h0000, 1'b0, 1'b0, 0, 1, 0, 0, 0);
      chk("dataMove", 16'h0, dataMove);
      run(16'h0612, 16'h0000, 1'b0, 1'b0, 0, 1, 0, 0, 0);
      run(16'h8012, 16'h0000, 1'b1, 1'b1, 0, 1, 0, 0, 0);
      run(16'h0880, 16'h0000, 1'b0, 1'b0, 0, 1, 0, 0, 0);
      chk("altSelect", 16'h0, altSelect);
      // Paired bit slot, both halves, register operand
      run(16'h7612, 16'h0000, 1'b0, 1'b0, 1, 1, 0, 0, 0);
      chk("altSelect", 16'h0, altSelect);
      run(16'h76f2, 16'h0000, 1'b0, 1'b0, 1, 1, 0, 0, 0);
      chk("altSelect", 16'h1, altSelect);
      // Memory bit operands, then peripheral fast and slow cost
      run(16'h7c00, 16'h7600, 1'b0, 1'b0, 3, 2, 0, 0, 1);
      run(16'h7f00, 16'h7000, 1'b0, 1'b0, 2, 2, 0, 0, 2);
      run(16'h7f00, 16'h7000, 1'b1, 1'b0, 2, 2, 0, 0, 2);
      run(16'h7f00, 16'h7000, 1'b1, 1'b1, 2, 2, 0, 0, 2);
      // Push and pop forms are plain moves
      run(16'h6df0, 16'h0000, 1'b0, 1'b0, 6, 0, 0, 0, 0);
      chk("dataMove", 16'h1, dataMove);
      // Unassigned slots with random low byte
      foreach (badOps[n]) run({badOps[n], rnd[7:0]}, 16'h0000, 1'b0, 1'b0, 7, -1, 0, 0, 0);
      // Random conditional branches
      repeat (4) run({4'h4, rnd[11:0]}, 16'h0000, 1'b0, 1'b0, 4, 2, 0, 0, 0);
      // Indirect call; a request held while busy waits
      sp0 = stackPtr;
      run(16'h5f30, 16'h0000, 1'b0, 1'b0, 5, 2, 1, 1, 0);
      chk("vecAddr", 16'h0030, vecAddr);
      chk("pushData", progCounter, pushData);
      instrWord = 16'h8012;
      @(negedge core_clk);
      chk("spWrite", 16'h1, spWrite);
      chk("spNext", sp0 - 16'h0002, spNext);
      chk("outValid", 16'h0, outValid);
      @(negedge core_clk);
      chk("pushWrite", 16'h1, pushWrite);
      @(negedge core_clk);
      chk("vecRead", 16'h1, vecRead);
      chk("busy", 16'h0, busy);
      @(negedge core_clk);
      decValid = 1'b0;
      chk("outValid", 16'h1, outValid);
      chk("opCode", 16'h0080, opCode);
      chk("stackPtr", sp0 - 16'h0002, stackPtr);
      chk("stackTop", progCounter, stackTop);
      endOfTest;
   end
endmodule

// ### verilog/cpd_cfg.svh
// Constants for the opcode decoder and state accounting block
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

// Opcode field positions in the first instruction word
`define CPD_OP_HI 15
`define CPD_OP_LO 8
`define CPD_ALT_BIT 7

// Per-cycle state costs
`define CPD_COST_MEM 2'h2
`define CPD_COST_INT 2'h1
`define CPD_COST_PERI_FAST 2'h2
`define CPD_COST_PERI_SLOW 2'h3
`define CPD_COST_NONE 2'h0

// Opcode bytes with special handling
`define CPD_OP_CALL_IND 8'h5f
`define CPD_OP_BIT_REG_MEM 8'h7c
`define CPD_OP_BIT_ABS 8'h7f
`define CPD_OP_BLOCK_MOVE 8'h7b

// Stack pointer step for a call
`define CPD_SP_STEP 16'h0002

// Reset values
`define CPD_RST_WORD 16'h0000
`define CPD_RST_BYTE 8'h00
`define CPD_RST_CNT 4'h0

`endif

// ### verilog/cpd_decoder.sv
// Top: instruction decode front end with execution state accounting
`timescale 1ns/10ps
`include "cpd_cfg.svh"
module cpd_decoder #(
   parameter int CNT_W = 4,
   parameter int STATE_W = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Decode request
   input wire logic decValid,
   input wire logic [15:0] instrWord,
   input wire logic [15:0] instrWord2,
   input wire logic periphAccess,
   input wire logic periphSlow,
   input wire logic [15:0] stackPtr,
   input wire logic [15:0] progCounter,
   // Decode result
   output logic outValid,
   output logic [7:0] opCode,
   output cpd_pkg::cpd_class_t opClass,
   output logic altSelect,
   output logic dataMove,
   output logic illegalOp,
   output logic periphFault,
   output logic [CNT_W-1:0] cntFetch,
   output logic [CNT_W-1:0] cntBranch,
   output logic [CNT_W-1:0] cntStack,
   output logic [CNT_W-1:0] cntByte,
   output logic [CNT_W-1:0] cntWord,
   output logic [CNT_W-1:0] cntInternal,
   output logic [STATE_W-1:0] execStates,
   // Indirect call sequence
   output logic busy,
   output logic spWrite,
   output logic [15:0] spNext,
   output logic pushWrite,
   output logic [15:0] pushData,
   output logic vecRead,
   output logic [7:0] vecAddr
);

   localparam int TW = CNT_W + 2;

   // Elaboration check: sums of six terms must fit
   if (CNT_W < 2 || STATE_W < TW + 3)
   begin : g_bad
      $error("cpd_decoder: CNT_W or STATE_W too small");
   end

   // All state of the block
   typedef struct packed {
      logic outValid;
      logic [7:0] opCode;
      cpd_pkg::cpd_class_t opClass;
      logic altSelect;
      logic dataMove;
      logic illegalOp;
      logic periphFault;
      logic [CNT_W-1:0] cI;
      logic [CNT_W-1:0] cJ;
      logic [CNT_W-1:0] cK;
      logic [CNT_W-1:0] cL;
      logic [CNT_W-1:0] cM;
      logic [CNT_W-1:0] cN;
      logic [STATE_W-1:0] states;
      cpd_pkg::cpd_state_t seq;
      logic busy;
      logic spWrite;
      logic [15:0] spNext;
      logic pushWrite;
      logic [15:0] pushData;
      logic vecRead;
      logic [7:0] vecAddr;
   } cpd_regs_t;

   cpd_regs_t regs_q;
   cpd_regs_t regs_d;

   cpd_pkg::cpd_class_t cls;
   logic dual;
   logic move;
   logic [CNT_W-1:0] nI;
   logic [CNT_W-1:0] nJ;
   logic [CNT_W-1:0] nK;
   logic [CNT_W-1:0] nL;
   logic [CNT_W-1:0] nM;
   logic [CNT_W-1:0] nN;
   logic [1:0] costL;
   logic [TW-1:0] tI;
   logic [TW-1:0] tJ;
   logic [TW-1:0] tK;
   logic [TW-1:0] tL;
   logic [TW-1:0] tM;
   logic [TW-1:0] tN;
   logic [STATE_W-1:0] sum;
   logic take;

   // Classifier
   cpd_op_class u_class (
      .firstWord(instrWord),
      .secondWord(instrWord2),
      .opClass(cls),
      .dualSlot(dual),
      .dataMove(move)
   );

   // Cycle counts per class
   always_comb
   begin
      nI = '0;
      nJ = '0;
      nK = '0;
      nL = '0;
      nM = '0;
      nN = '0;
      case (cls)
         cpd_pkg::CL_ALU:
         begin
            nI = CNT_W'(1);
         end
         cpd_pkg::CL_BIT_REG:
         begin
            nI = CNT_W'(1);
         end
         cpd_pkg::CL_BIT_RMW:
         begin
            nI = CNT_W'(2);
            nL = CNT_W'(2);
         end
         // memory operand, two fetches one byte read
         cpd_pkg::CL_BIT_RD:
         begin
            nI = CNT_W'(2);
            nL = CNT_W'(1);
         end
         cpd_pkg::CL_BRANCH:
         begin
            nI = CNT_W'(2);
         end
         cpd_pkg::CL_CALL_IND:
         begin
            nI = CNT_W'(2);
            nJ = CNT_W'(1);
            nK = CNT_W'(1);
         end
         default:
         begin
            nI = '0;
         end
      endcase
   end

   // byte cost switches to peripheral cost when flagged
   // peripheral byte cost 2 or 3
   always_comb
   begin
      if (periphAccess)
      begin
         costL = periphSlow ? `CPD_COST_PERI_SLOW : `CPD_COST_PERI_FAST;
      end
      else
      begin
         costL = `CPD_COST_MEM;
      end
   end

   // memory cost 2, internal cost 1
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tI (
      .cycleCount(nI), .stateCost(`CPD_COST_MEM), .stateTerm(tI));
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tJ (
      .cycleCount(nJ), .stateCost(`CPD_COST_MEM), .stateTerm(tJ));
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tK (
      .cycleCount(nK), .stateCost(`CPD_COST_MEM), .stateTerm(tK));
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tL (
      .cycleCount(nL), .stateCost(costL), .stateTerm(tL));
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tM (
      .cycleCount(nM), .stateCost(`CPD_COST_MEM), .stateTerm(tM));
   cpd_state_term #(.CW(CNT_W), .SW(2)) u_tN (
      .cycleCount(nN), .stateCost(`CPD_COST_INT), .stateTerm(tN));

   // weighted sum over six cycle types
   assign sum = STATE_W'(tI) + STATE_W'(tJ) + STATE_W'(tK)
      + STATE_W'(tL) + STATE_W'(tM) + STATE_W'(tN);

   // Request taken only while the call sequencer is idle
   assign take = decValid && (regs_q.seq == cpd_pkg::ST_IDLE);

   // Next-state logic
   always_comb
   begin
      regs_d = regs_q;
      regs_d.outValid = 1'b0;
      regs_d.spWrite = 1'b0;
      regs_d.pushWrite = 1'b0;
      regs_d.vecRead = 1'b0;
      if (take)
      begin
         regs_d.outValid = 1'b1;
         regs_d.opCode = instrWord[`CPD_OP_HI:`CPD_OP_LO];
         regs_d.opClass = cls;
         // bit 7 selects within a paired slot
         regs_d.altSelect = dual & instrWord[`CPD_ALT_BIT];
         // push and pop reported as data moves
         regs_d.dataMove = move;
         regs_d.illegalOp = (cls == cpd_pkg::CL_ILLEGAL);
         // only byte access reaches a peripheral
         regs_d.periphFault = periphAccess && (nL == '0);
         regs_d.cI = nI;
         regs_d.cJ = nJ;
         regs_d.cK = nK;
         regs_d.cL = nL;
         regs_d.cM = nM;
         regs_d.cN = nN;
         regs_d.states = sum;
         if (cls == cpd_pkg::CL_CALL_IND)
         begin
            regs_d.seq = cpd_pkg::ST_SP_DEC;
            regs_d.vecAddr = instrWord[7:0];
            regs_d.pushData = progCounter;
         end
      end
      // decrement SP, push PC, then read the vector
      case (regs_q.seq)
         cpd_pkg::ST_SP_DEC:
         begin
            regs_d.spWrite = 1'b1;
            regs_d.spNext = stackPtr - `CPD_SP_STEP;
            regs_d.seq = cpd_pkg::ST_PUSH;
         end
         cpd_pkg::ST_PUSH:
         begin
            regs_d.pushWrite = 1'b1;
            regs_d.seq = cpd_pkg::ST_LOAD;
         end
         cpd_pkg::ST_LOAD:
         begin
            regs_d.vecRead = 1'b1;
            regs_d.seq = cpd_pkg::ST_IDLE;
         end
         default:
         begin
            regs_d.seq = regs_d.seq;
         end
      endcase
      // Registered busy so the port comes from a flip-flop
      regs_d.busy = (regs_d.seq != cpd_pkg::ST_IDLE);
   end

   // State register
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         regs_q <= '{
            outValid: 1'b0,
            opCode: `CPD_RST_BYTE,
            opClass: cpd_pkg::CL_ALU,
            altSelect: 1'b0,
            dataMove: 1'b0,
            illegalOp: 1'b0,
            periphFault: 1'b0,
            cI: '0,
            cJ: '0,
            cK: '0,
            cL: '0,
            cM: '0,
            cN: '0,
            states: '0,
            seq: cpd_pkg::ST_IDLE,
            busy: 1'b0,
            spWrite: 1'b0,
            spNext: `CPD_RST_WORD,
            pushWrite: 1'b0,
            pushData: `CPD_RST_WORD,
            vecRead: 1'b0,
            vecAddr: `CPD_RST_BYTE
         };
      end
      else
      begin
         regs_q <= regs_d;
      end
   end

   // Outputs straight from the state register
   assign outValid = regs_q.outValid;
   assign opCode = regs_q.opCode;
   assign opClass = regs_q.opClass;
   assign altSelect = regs_q.altSelect;
   assign dataMove = regs_q.dataMove;
   assign illegalOp = regs_q.illegalOp;
   assign periphFault = regs_q.periphFault;
   assign cntFetch = regs_q.cI;
   assign cntBranch = regs_q.cJ;
   assign cntStack = regs_q.cK;
   assign cntByte = regs_q.cL;
   assign cntWord = regs_q.cM;
   assign cntInternal = regs_q.cN;
   assign execStates = regs_q.states;
   assign busy = regs_q.busy;
   assign spWrite = regs_q.spWrite;
   assign spNext = regs_q.spNext;
   assign pushWrite = regs_q.pushWrite;
   assign pushData = regs_q.pushData;
   assign vecRead = regs_q.vecRead;
   assign vecAddr = regs_q.vecAddr;

endmodule

// ### verilog/cpd_op_class.sv
// Opcode classifier: first word and optional second word to class
`timescale 1ns/10ps
`include "cpd_cfg.svh"
module cpd_op_class (
   // Instruction words
   input wire logic [15:0] firstWord,
   input wire logic [15:0] secondWord,
   // Classification
   output cpd_pkg::cpd_class_t opClass,
   output logic dualSlot,
   output logic dataMove
);

   logic [7:0] op;
   logic [7:0] op2;

   assign op = firstWord[`CPD_OP_HI:`CPD_OP_LO];
   assign op2 = secondWord[`CPD_OP_HI:`CPD_OP_LO];

   // Class lookup over the opcode map
   always_comb
   begin
      opClass = cpd_pkg::CL_ILLEGAL;
      dualSlot = 1'b0;
      dataMove = 1'b0;
      if (op[7:5] == 3'b000)
      begin
         opClass = cpd_pkg::CL_ALU;
         dualSlot = (op[7:4] == 4'h1) && (op[3:2] == 2'b00 || op[3:0] == 4'h7);
         dataMove = (op == 8'h0c) || (op == 8'h0d);
      end
      else if (op[7] == 1'b1)
      begin
         opClass = cpd_pkg::CL_ALU;
         dataMove = (op[7:4] == 4'hf);
      end
      else if (op[7:5] == 3'b001)
      begin
         opClass = cpd_pkg::CL_OTHER;
         dataMove = 1'b1;
      end
      else if (op[7:4] == 4'h4)
      begin
         opClass = cpd_pkg::CL_BRANCH;
      end
      else if (op == `CPD_OP_CALL_IND)
      begin
         opClass = cpd_pkg::CL_CALL_IND;
      end
      else if (op[7:4] == 4'h5)
      begin
         if (op == 8'h52 || op == 8'h53 || op == 8'h57 || op == 8'h58 || op == 8'h5c)
         begin
            opClass = cpd_pkg::CL_ILLEGAL;
         end
         else
         begin
            opClass = cpd_pkg::CL_OTHER;
         end
      end
      else if (op[7:4] == 4'h6)
      begin
         if (op[3:2] == 2'b00 || op == 8'h67)
         begin
            opClass = cpd_pkg::CL_BIT_REG;
            dualSlot = (op == 8'h67);
         end
         else if (op[3] == 1'b1)
         begin
            // stack push and pop share these encodings
            opClass = cpd_pkg::CL_OTHER;
            dataMove = 1'b1;
         end
      end
      else if (op[7:3] == 5'b01110)
      begin
         opClass = cpd_pkg::CL_BIT_REG;
         dualSlot = (op[2] == 1'b1);
      end
      else if (op == `CPD_OP_BLOCK_MOVE)
      begin
         opClass = cpd_pkg::CL_OTHER;
      end
      else if (op[7:2] == 6'(`CPD_OP_BIT_REG_MEM >> 2))
      begin
         // writing bit ops on memory are read-modify-write
         if (op2[7:2] == 6'h18 && op2[1:0] != 2'b11)
         begin
            opClass = cpd_pkg::CL_BIT_RMW;
         end
         else if (op2[7:4] == 4'h7 && op2[3:2] == 2'b00 && op2[1:0] != 2'b11)
         begin
            opClass = cpd_pkg::CL_BIT_RMW;
         end
         else if (op2 == 8'h67)
         begin
            opClass = cpd_pkg::CL_BIT_RMW;
            dualSlot = 1'b1;
         end
         else if (op2 == 8'h63 || op2 == 8'h73 || op2[7:2] == 6'h1d)
         begin
            opClass = cpd_pkg::CL_BIT_RD;
            dualSlot = (op2[7:2] == 6'h1d);
         end
      end
   end

endmodule

// ### verilog/cpd_pkg.sv
// Types for the opcode decoder and state accounting block
package cpd_pkg;

   // Decoded instruction class
   typedef enum logic [2:0] {
      CL_ALU = 3'b000,
      CL_BIT_REG = 3'b001,
      CL_BIT_RMW = 3'b010,
      CL_BIT_RD = 3'b011,
      CL_BRANCH = 3'b100,
      CL_CALL_IND = 3'b101,
      CL_OTHER = 3'b110,
      CL_ILLEGAL = 3'b111
   } cpd_class_t;

   // Sequencer for the memory-indirect call
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SP_DEC = 2'b01,
      ST_PUSH = 2'b10,
      ST_LOAD = 2'b11
   } cpd_state_t;

endpackage

// ### verilog/cpd_state_term.sv
// One weighted term: cycle count times per-cycle state cost
`timescale 1ns/10ps
module cpd_state_term #(
   parameter int CW = 4,
   parameter int SW = 2
) (
   // Operands
   input wire logic [CW-1:0] cycleCount,
   input wire logic [SW-1:0] stateCost,
   // Product
   output logic [CW+SW-1:0] stateTerm
);

   // Elaboration check on widths
   if (CW < 1 || SW < 2)
   begin : g_bad
      $error("cpd_state_term: widths too small");
   end

   // Product at full width
   always_comb
   begin
      stateTerm = (CW+SW)'(cycleCount) * (CW+SW)'(stateCost);
   end

endmodule
